// ### hw/aio_mux_pkg.sv
// Constants, carrier types and helpers for the second analog pin mux.
// Assumes one 125 MHz system clock and APB access from a single bus.
package aio_mux_pkg;

  // Pin counts: ten analog pins, four of them digital-capable
  localparam int NUM_PINS = 10;
  localparam int NUM_DIO  = 4;

  // Register byte offsets within this block's own window
  localparam logic [7:0] FUNC_SEL_OFFSET    = 8'h00;
  localparam logic [7:0] DATA_OFFSET        = 8'h04;
  localparam logic [7:0] DIR_OFFSET         = 8'h08;
  localparam logic [7:0] SET_OFFSET         = 8'h0C;
  localparam logic [7:0] CLEAR_OFFSET       = 8'h10;
  localparam logic [7:0] MODE_STATUS_OFFSET = 8'h14;

  // Only odd select bits are kept; reset puts every pin in analog mode
  localparam logic [31:0] ODD_BIT_MASK   = 32'hAAAAAAAA;
  localparam logic [31:0] FUNC_SEL_RESET = 32'hAAAAAAAA;
  localparam logic [3:0]  DATA_RESET     = 4'h0;
  localparam logic [3:0]  DIR_RESET      = 4'h0;

  // Select bit of each digital pin: gpio_a2, gpio_a4, gpio_a6, gpio_b4
  localparam logic [4:0] SEL_BIT_A2 = 5'h05;
  localparam logic [4:0] SEL_BIT_A4 = 5'h09;
  localparam logic [4:0] SEL_BIT_A6 = 5'h0D;
  localparam logic [4:0] SEL_BIT_B4 = 5'h19;

  // Position of each digital pin among the ten pins
  localparam logic [3:0] PIN_IDX_A2 = 4'h1;
  localparam logic [3:0] PIN_IDX_A4 = 4'h3;
  localparam logic [3:0] PIN_IDX_A6 = 4'h4;
  localparam logic [3:0] PIN_IDX_B4 = 4'h8;

  // Pins that never offer a digital function
  localparam logic [9:0] ANALOG_ONLY_MASK = 10'h2E5;

  // Register request as seen by the register file
  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } reg_req_t;

  // Per-pin configuration handed to a pin cell
  typedef struct packed {
    logic digital;
    logic drive;
    logic level;
  } dio_cfg_t;

  // Widen a four-bit field into a bus word, upper bits zero
  function automatic logic [31:0] word4(input logic [3:0] v);
    return {28'h0000000, v};
  endfunction

  // Select bit of digital pin number n (0..3)
  function automatic logic [4:0] dio_sel_bit(input int n);
    case (n)
      0:       return SEL_BIT_A2;
      1:       return SEL_BIT_A4;
      2:       return SEL_BIT_A6;
      default: return SEL_BIT_B4;
    endcase
  endfunction

endpackage

// ### hw/apb_reg_port.sv
// APB slave front end: zero wait states, registered read data and error.
// Assumes the register file decodes addresses and supplies read data.
`timescale 1ns/100ps
module apb_reg_port
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic                  master_ok,
  input  wire logic                  addr_hit,
  input  wire logic [31:0]           rd_word,
  output aio_mux_pkg::reg_req_t      req,
  output logic                       wr_en,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);

  logic        setup;
  logic        allow;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // Request passes straight to the decoder
  assign req   = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign setup = psel && !penable;
  assign allow = master_ok && addr_hit;

  // Write takes effect only at the access edge of a permitted access
  assign wr_en  = psel && penable && pwrite && allow;
  assign pready = psel && penable;

  // Answer is prepared in setup so it comes from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q  <= (allow && !pwrite) ? rd_word : 32'h00000000;
      pslverr_q <= !allow;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule // apb_reg_port

// ### hw/aio_dio_cell.sv
// One digital-capable analog pin: mode, direction and input sampling.
// Assumes the pad input is synchronous to pclk.
`timescale 1ns/100ps
module aio_dio_cell
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  aio_mux_pkg::dio_cfg_t      cfg,
  input  wire logic                  pad_in,
  output logic                       pad_out,
  output logic                       pad_oe,
  output logic                       analog_en,
  output logic                       in_q
);

  // Outputs registered; analog after reset, pad never driven in analog
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      analog_en <= 1'b1;
      pad_oe    <= 1'b0;
      pad_out   <= 1'b0;
    end
    else
    begin
      analog_en <= !cfg.digital;
      pad_oe    <= cfg.digital && cfg.drive;
      pad_out   <= cfg.digital && cfg.drive && cfg.level;
    end
  end

  // Input is sampled only in digital mode so analog levels read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_q <= 1'b0;
    else
      in_q <= cfg.digital && pad_in;
  end

endmodule // aio_dio_cell

// ### hw/second_analog_pin_mux.sv
// Second analog pin mux: ten analog pins, four with a plain digital port.
// Assumes APB from the system interconnect plus a sideband level that
// marks transfers issued by the control-subsystem processor.
//
// Behaviour
// - Reset routes every pin to its analog input, no digital port active.
// - Odd select bit 5, 9, 13 or 25 at 0 puts its pin in digital mode on its port.
// - An odd select bit at 1 routes its pin to converter or comparator.
// - Even select bits are not stored and have no effect on routing.
// - Select bit 9 switches the A4 pin between gpio_a4 and analog.
// - Only the A2, A4, A6 and B4 pins have a digital port; six stay analog.
// - Software reads and writes the four digital bits and each direction.
// - The digital pins have no pull-up and no pull-up control bits exist.
// - Only the control-subsystem processor reaches these registers.
// - This mux has a register set of its own, apart from the first mux.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module second_analog_pin_mux
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic              master_is_control_cpu,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        dio_pad_in,
  output logic      [3:0]        dio_pad_out,
  output logic      [3:0]        dio_pad_oe,
  output logic      [9:0]        analog_route_en
);

  // The offsets fill eight address bits
  if (ADDR_W != 8)
  begin : g_addr_w_check
    $error("second_analog_pin_mux: ADDR_W must be 8");
  end

  aio_mux_pkg::reg_req_t  req;
  aio_mux_pkg::dio_cfg_t  cfg [aio_mux_pkg::NUM_DIO];
  logic                   wr_en;
  logic                   addr_hit;
  logic [31:0]            rd_word;
  logic [31:0]            func_sel_q;
  logic [3:0]             out_q;
  logic [3:0]             dir_q;
  logic [3:0]             digital;
  logic [3:0]             in_q;
  logic [3:0]             cell_analog;
  logic [3:0]             data_view;

  // Bus front end; only this block's own window is decoded here, the
  // first mux keeps a separate register set elsewhere
  apb_reg_port u_port
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .master_ok (master_is_control_cpu),
    .addr_hit  (addr_hit),
    .rd_word   (rd_word),
    .req       (req),
    .wr_en     (wr_en),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr)
  );

  // Decode: mode status is read-only, a write to it is refused
  always_comb
  begin
    case (req.addr)
      aio_mux_pkg::FUNC_SEL_OFFSET,
      aio_mux_pkg::DATA_OFFSET,
      aio_mux_pkg::DIR_OFFSET,
      aio_mux_pkg::SET_OFFSET,
      aio_mux_pkg::CLEAR_OFFSET:       addr_hit = 1'b1;
      aio_mux_pkg::MODE_STATUS_OFFSET: addr_hit = !req.write;
      default:                         addr_hit = 1'b0;
    endcase
  end

  // Function select: only odd bits are stored, reset is all analog
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      func_sel_q <= aio_mux_pkg::FUNC_SEL_RESET;
    else if (wr_en && req.addr == aio_mux_pkg::FUNC_SEL_OFFSET)
      func_sel_q <= req.wdata & aio_mux_pkg::ODD_BIT_MASK;
  end

  // Output latch: direct write, or set and clear for single bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= aio_mux_pkg::DATA_RESET;
    else if (wr_en)
    begin
      case (req.addr)
        aio_mux_pkg::DATA_OFFSET:  out_q <= req.wdata[3:0];
        aio_mux_pkg::SET_OFFSET:   out_q <= out_q | req.wdata[3:0];
        aio_mux_pkg::CLEAR_OFFSET: out_q <= out_q & ~req.wdata[3:0];
        default:                   out_q <= out_q;
      endcase
    end
  end

  // Direction: 1 drives the pin, 0 listens; no pull-up bits exist
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= aio_mux_pkg::DIR_RESET;
    else if (wr_en && req.addr == aio_mux_pkg::DIR_OFFSET)
      dir_q <= req.wdata[3:0];
  end

  // Each digital pin follows its own odd select bit
  generate
    for (genvar i = 0; i < aio_mux_pkg::NUM_DIO; i++)
    begin : g_dio
      assign digital[i] = !func_sel_q[aio_mux_pkg::dio_sel_bit(i)];
      assign cfg[i]     = '{digital: digital[i], drive: dir_q[i],
                            level: out_q[i]};
      aio_dio_cell u_cell
      (
        .pclk      (pclk),
        .presetn   (presetn),
        .cfg       (cfg[i]),
        .pad_in    (dio_pad_in[i]),
        .pad_out   (dio_pad_out[i]),
        .pad_oe    (dio_pad_oe[i]),
        .analog_en (cell_analog[i]),
        .in_q      (in_q[i])
      );
    end
  endgenerate

  // Analog-only pins stay routed whatever the select register holds
  always_comb
  begin
    analog_route_en             = aio_mux_pkg::ANALOG_ONLY_MASK;
    analog_route_en[aio_mux_pkg::PIN_IDX_A2] = cell_analog[0];
    analog_route_en[aio_mux_pkg::PIN_IDX_A4] = cell_analog[1];
    analog_route_en[aio_mux_pkg::PIN_IDX_A6] = cell_analog[2];
    analog_route_en[aio_mux_pkg::PIN_IDX_B4] = cell_analog[3];
  end

  // Data reads: driven bits show the latch, listening bits the pad,
  // analog pins read zero since their level means nothing digital
  assign data_view = (dir_q & out_q & digital) | (~dir_q & in_q);

  // Read mux; set and clear read back the latch for convenience
  always_comb
  begin
    case (req.addr)
      aio_mux_pkg::FUNC_SEL_OFFSET:    rd_word = func_sel_q;
      aio_mux_pkg::DATA_OFFSET:        rd_word = aio_mux_pkg::word4(data_view);
      aio_mux_pkg::DIR_OFFSET:         rd_word = aio_mux_pkg::word4(dir_q);
      aio_mux_pkg::SET_OFFSET,
      aio_mux_pkg::CLEAR_OFFSET:       rd_word = aio_mux_pkg::word4(out_q);
      aio_mux_pkg::MODE_STATUS_OFFSET: rd_word = aio_mux_pkg::word4(digital);
      default:                         rd_word = 32'h00000000;
    endcase
  end

  // First edge after reset: all analog, nothing driven
  reset_analog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn)
      |-> (analog_route_en == '1 && dio_pad_oe == '0))
    else $error("pins not all analog after reset");

  // First edge after reset: no level driven, select word at its reset
  reset_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn)
      |-> (dio_pad_out == '0 && func_sel_q == aio_mux_pkg::FUNC_SEL_RESET))
    else $error("pad level or select word not at reset value");

  // A2 digital one edge after its select bit clears
  a2_digital_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_sel_q[aio_mux_pkg::SEL_BIT_A2]
      |=> !analog_route_en[aio_mux_pkg::PIN_IDX_A2])
    else $error("A2 pin not digital with its select bit clear");

  // A4 digital one edge after bit 9 clears
  a4_digital_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_sel_q[aio_mux_pkg::SEL_BIT_A4]
      |=> !analog_route_en[aio_mux_pkg::PIN_IDX_A4])
    else $error("A4 pin not digital with bit 9 clear");

  // A6 digital one edge after bit 13 clears
  a6_digital_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_sel_q[aio_mux_pkg::SEL_BIT_A6]
      |=> !analog_route_en[aio_mux_pkg::PIN_IDX_A6])
    else $error("A6 pin not digital with bit 13 clear");

  // B4 digital one edge after bit 25 clears
  b4_digital_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !func_sel_q[aio_mux_pkg::SEL_BIT_B4]
      |=> !analog_route_en[aio_mux_pkg::PIN_IDX_B4])
    else $error("B4 pin not digital with bit 25 clear");

  // A2 analog and undriven one edge after its select bit sets
  a2_analog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    func_sel_q[aio_mux_pkg::SEL_BIT_A2]
      |=> (analog_route_en[aio_mux_pkg::PIN_IDX_A2] && !dio_pad_oe[0]))
    else $error("A2 pin not analog with its select bit set");

  // A4 analog and undriven one edge after bit 9 sets
  a4_analog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    func_sel_q[aio_mux_pkg::SEL_BIT_A4]
      |=> (analog_route_en[aio_mux_pkg::PIN_IDX_A4] && !dio_pad_oe[1]))
    else $error("A4 pin not analog with bit 9 set");

  // A6 analog and undriven one edge after its select bit sets
  a6_analog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    func_sel_q[aio_mux_pkg::SEL_BIT_A6]
      |=> (analog_route_en[aio_mux_pkg::PIN_IDX_A6] && !dio_pad_oe[2]))
    else $error("A6 pin not analog with bit 13 set");

  // B4 analog and undriven one edge after bit 25 sets
  b4_analog_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    func_sel_q[aio_mux_pkg::SEL_BIT_B4]
      |=> (analog_route_en[aio_mux_pkg::PIN_IDX_B4] && !dio_pad_oe[3]))
    else $error("B4 pin not analog with bit 25 set");

  // Even bits never stored
  even_bits_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && req.addr == aio_mux_pkg::FUNC_SEL_OFFSET)
      |=> func_sel_q == ($past(req.wdata) & aio_mux_pkg::ODD_BIT_MASK))
    else $error("select register kept an even bit");

  // Only stored odd bits steer: a steady select word keeps every route
  route_steady_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $stable(func_sel_q)
      |=> $stable(analog_route_en))
    else $error("route changed with no select bit change");

  // Bit 9 picks A4 mode both ways
  a4_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(func_sel_q[aio_mux_pkg::SEL_BIT_A4])
      |=> (analog_route_en[aio_mux_pkg::PIN_IDX_A4]
           == $past(func_sel_q[aio_mux_pkg::SEL_BIT_A4])))
    else $error("A4 pin mode does not follow select bit 9");

  // Six pins are analog at all times
  analog_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (analog_route_en & aio_mux_pkg::ANALOG_ONLY_MASK)
      == aio_mux_pkg::ANALOG_ONLY_MASK)
    else $error("analog-only pin lost its analog route");

  // Mode status reports the four digital pins and nothing more
  status_view_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == aio_mux_pkg::MODE_STATUS_OFFSET)
      |=> prdata[31:4] == '0)
    else $error("mode status shows more than four pins");

  // B4 driven from the latch when digital and set to output
  dir_output_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dir_q[3] && !func_sel_q[aio_mux_pkg::SEL_BIT_B4])
      |=> (dio_pad_oe[3] && dio_pad_out[3] == $past(out_q[3])))
    else $error("B4 output not driven from latch");

  // Direction word takes the low four bits of a permitted write
  dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && req.addr == aio_mux_pkg::DIR_OFFSET)
      |=> dir_q == $past(req.wdata[3:0]))
    else $error("direction word not taken from write");

  // Set word ORs ones into the output latch
  set_bits_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && req.addr == aio_mux_pkg::SET_OFFSET)
      |=> out_q == ($past(out_q) | $past(req.wdata[3:0])))
    else $error("set word did not raise latch bits");

  // Clear word drops the latch bits written as ones
  clear_bits_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && req.addr == aio_mux_pkg::CLEAR_OFFSET)
      |=> out_q == ($past(out_q) & ~$past(req.wdata[3:0])))
    else $error("clear word did not drop latch bits");

  // A listening digital A2 pin is sampled every edge
  input_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!dir_q[0] && !func_sel_q[aio_mux_pkg::SEL_BIT_A2])
      |=> in_q[0] == $past(dio_pad_in[0]))
    else $error("A2 input not sampled from its pad");

  // Direction word has four bits and nothing above, no pull-up field
  no_pullup_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == aio_mux_pkg::DIR_OFFSET)
      |=> prdata[31:4] == '0)
    else $error("direction word shows bits beyond the four pins");

  // Refused master: error, zero data, no register changes
  denied_access_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !master_is_control_cpu)
      ##1 (psel && penable)
      |-> (pslverr && prdata == '0)
          ##1 (func_sel_q == $past(func_sel_q) && dir_q == $past(dir_q)
               && out_q == $past(out_q)))
    else $error("access by other master not refused");

  // Permitted direction-word access answers in its first access cycle, no error
  apb_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && master_is_control_cpu
     && paddr == aio_mux_pkg::DIR_OFFSET) ##1 (psel && penable)
      |-> (pready && !pslverr))
    else $error("permitted access not answered cleanly");

  // Status word is read-only: a write to it is refused
  status_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && pwrite
     && paddr == aio_mux_pkg::MODE_STATUS_OFFSET)
      |=> pslverr)
    else $error("write to mode status not refused");

  // Words past this block's own set are refused with zero data
  window_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr > aio_mux_pkg::MODE_STATUS_OFFSET)
      |=> (pslverr && prdata == '0))
    else $error("word outside own register set not refused");

endmodule // second_analog_pin_mux

// ### sim/tb_second_analog_pin_mux.sv
// Self-checking bench for the second analog pin mux.
// Assumes the design's own assertions; drives APB and pads directly.
`timescale 1ns/100ps
module tb_second_analog_pin_mux;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        master_is_control_cpu;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  dio_pad_in;
  logic [3:0]  dio_pad_out;
  logic [3:0]  dio_pad_oe;
  logic [9:0]  analog_route_en;
  int          err_total;
  int          samples_checked;
  // Select bit and pin position of each digital pin, a2 a4 a6 b4
  int          sel_bit [4] = '{5, 9, 13, 25};
  int          pin_idx [4] = '{1, 3, 4, 8};

  second_analog_pin_mux #(.ADDR_W(8)) i_second_analog_pin_mux
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .master_is_control_cpu (master_is_control_cpu),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .dio_pad_in            (dio_pad_in),
    .dio_pad_out           (dio_pad_out),
    .dio_pad_oe            (dio_pad_oe),
    .analog_route_en       (analog_route_en)
  );

  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("access cycles", 32'h00000001, n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write pslverr", {31'h0, ee}, {31'h0, e});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk("read pslverr", {31'h0, ee}, {31'h0, e});
    chk("prdata", x, r);
  endtask

  // Let register and pin updates land, then compare the pin side
  task automatic pins(input logic [9:0] rt, input logic [3:0] oe,
                      input logic [3:0] o);
    repeat (2) @(posedge pclk);
    #1;
    chk("analog_route_en", {22'h0, rt}, {22'h0, analog_route_en});
    chk("dio_pad_oe", {28'h0, oe}, {28'h0, dio_pad_oe});
    chk("dio_pad_out", {28'h0, o}, {28'h0, dio_pad_out});
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic test_reset_state;
    pins(10'h3FF, 4'h0, 4'h0);
    rdc(aio_mux_pkg::FUNC_SEL_OFFSET, aio_mux_pkg::FUNC_SEL_RESET, 0);
    rdc(aio_mux_pkg::MODE_STATUS_OFFSET, 32'h00000000, 0);
    rdc(aio_mux_pkg::DIR_OFFSET, 32'h00000000, 0);
  endtask

  // Even bits set, odd bits clear: all four digital, others analog
  task automatic test_odd_even;
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'h55555555, 0);
    pins(10'h2E5, 4'h0, 4'h0);
    rdc(aio_mux_pkg::FUNC_SEL_OFFSET, 32'h00000000, 0);
    rdc(aio_mux_pkg::MODE_STATUS_OFFSET, 32'h0000000F, 0);
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'hFFFFFFFF, 0);
    // One route enable per shared pin; picking converter or comparator
    // is left to the destination's own enables, never set here
    pins(10'h3FF, 4'h0, 4'h0);
  endtask

  // Each select bit alone moves only its own pin
  task automatic test_each_select;
    logic [31:0] v;
    for (int n = 0; n < 4; n++)
    begin
      v = 32'hAAAAAAAA & ~(32'h1 << sel_bit[n]);
      wr(aio_mux_pkg::FUNC_SEL_OFFSET, v, 0);
      pins(10'h3FF & ~(10'h1 << pin_idx[n]), 4'h0, 4'h0);
      rdc(aio_mux_pkg::MODE_STATUS_OFFSET, 32'h1 << n, 0);
    end
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'hAAAAAAA8, 0);
    pins(10'h3FF, 4'h0, 4'h0);
  endtask

  task automatic test_data_dir;
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'h00000000, 0);
    wr(aio_mux_pkg::DIR_OFFSET, 32'h0000000F, 0);
    wr(aio_mux_pkg::DATA_OFFSET, 32'h0000000A, 0);
    pins(10'h2E5, 4'hF, 4'hA);
    wr(aio_mux_pkg::SET_OFFSET, 32'h00000005, 0);
    pins(10'h2E5, 4'hF, 4'hF);
    wr(aio_mux_pkg::CLEAR_OFFSET, 32'h00000003, 0);
    pins(10'h2E5, 4'hF, 4'hC);
    rdc(aio_mux_pkg::DATA_OFFSET, 32'h0000000C, 0);
    rdc(aio_mux_pkg::DIR_OFFSET, 32'h0000000F, 0);
    wr(aio_mux_pkg::DIR_OFFSET, 32'h00000003, 0);
    dio_pad_in <= 4'h5;
    pins(10'h2E5, 4'h3, 4'h0);
    rdc(aio_mux_pkg::DATA_OFFSET, 32'h00000004, 0);
    // Back to analog: outputs must drop even with direction out
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'hAAAAAAAA, 0);
    pins(10'h3FF, 4'h0, 4'h0);
    rdc(aio_mux_pkg::DATA_OFFSET, 32'h00000000, 0);
  endtask

  // Refusals: foreign master, read-only status, unmapped word
  task automatic test_refusals;
    master_is_control_cpu <= 1'b0;
    wr(aio_mux_pkg::DIR_OFFSET, 32'h0000000C, 1);
    rdc(aio_mux_pkg::DIR_OFFSET, 32'h00000000, 1);
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'h00000000, 1);
    master_is_control_cpu <= 1'b1;
    pins(10'h3FF, 4'h0, 4'h0);
    rdc(aio_mux_pkg::DIR_OFFSET, 32'h00000003, 0);
    wr(aio_mux_pkg::MODE_STATUS_OFFSET, 32'h0000000F, 1);
    rdc(8'h18, 32'h00000000, 1);
    wr(8'h18, 32'hFFFFFFFF, 1);
    rdc(aio_mux_pkg::MODE_STATUS_OFFSET, 32'h00000000, 0);
  endtask

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish();
  end

  initial
  begin
    err_total = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    master_is_control_cpu = 1'b1;
    dio_pad_in = 4'h0;
    do_reset();
    test_reset_state();
    test_odd_even();
    test_each_select();
    test_data_dir();
    test_refusals();
    // Mid-run reset after outputs were configured
    wr(aio_mux_pkg::FUNC_SEL_OFFSET, 32'h00000000, 0);
    pins(10'h2E5, 4'h3, 4'h0);
    do_reset();
    test_reset_state();
    tally_and_finish();
  end
endmodule // tb_second_analog_pin_mux
